// file: dv/tb.sv
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POR = 1024;
   localparam int WAKE [4] = '{3072, 4096, 1024, 2048};
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        brownout_det = 1'b0;
   logic        sleep_req = 1'b0;
   logic [31:0] rd;
   logic [31:0] c0;
   int          k;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   wire logic        hreadyout, hresp, timer_pin, master_clear_pin;
   wire logic        core_reset_n, timer_irq, wake_pulse;
   wire logic [31:0] hrdata;
   wire logic [10:0] reset_vector;

   twr_top #(.P_POR_DIV(16'h1), .P_WAKE_DIV0(16'h3), .P_WAKE_DIV1(16'h4),
      .P_WAKE_DIV2(16'h1), .P_WAKE_DIV3(16'h2)) dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .timer_pin, .master_clear_pin, .brownout_det, .sleep_req, .core_reset_n,
      .reset_vector, .timer_irq, .wake_pulse);
   twr_pin_model pins (.hclk, .timer_pin, .master_clear_pin);

   always #12.5 hclk = ~hclk;

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsize  <= 3'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wait_sig(input bit wake, input logic lvl, input int lo, input int hi);
      int n;
      n = 0;
      while ((wake ? wake_pulse : core_reset_n) !== lvl && n <= hi)
      begin
         @(posedge hclk);
         n++;
      end
      check(32'(n >= lo && n <= hi), 32'h1);
   endtask : wait_sig

   task automatic recover(input int cause, input int lo);
      wait_sig(1'b0, 1'b1, lo, POR + 16);
      bus(1'b0, 32'h10, 32'h0);
      check(32'(rd[cause]), 32'h1);
      bus(1'b1, 32'h10, 32'h1c);
      $display("reset cause %0d done", cause);
   endtask : recover

   task automatic ext_reset(input logic bo);
      if (bo)
         brownout_det <= 1'b1;
      else
         pins.clear_level(1'b0);
      repeat (300) @(posedge hclk);
      check(32'(core_reset_n), 32'h0);
      check(32'(reset_vector), 32'h7ff);
      bus(1'b0, 32'h0, 32'h0);
      check(rd, 32'hff);
      if (bo)
         brownout_det <= 1'b0;
      else
         pins.clear_level(1'b1);
      recover(bo ? 3 : 4, POR);
   endtask : ext_reset

   task automatic wdt_run(input logic [31:0] opt, input int lim);
      bus(1'b1, 32'h8, 32'h7);
      bus(1'b1, 32'h0, opt);
      bus(1'b1, 32'hc, 32'h0);
      wait_sig(1'b0, 1'b0, lim - 2, lim + 16);
      bus(1'b1, 32'h8, 32'h3);
      recover(2, POR - 16);
   endtask : wdt_run

   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (40) @(posedge hclk);
      check(32'(core_reset_n), 32'h0);
      check(32'(reset_vector), 32'h7ff);
      check(32'({hreadyout, hresp}), 32'h2);
      bus(1'b0, 32'h0, 32'h0);
      check(rd, 32'hff);
      bus(1'b0, 32'h8, 32'h0);
      check(rd, 32'h3);
      pins.clear_level(1'b1);
      wait_sig(1'b0, 1'b1, POR, POR + 16);
      $display("power-up done");
      for (int n = 0; n < 9; n++)
      begin
         bus(1'b1, 32'h0, (n == 8) ? 32'h8 : 32'(n));
         bus(1'b0, 32'h4, 32'h0);
         c0 = rd;
         repeat (((n == 8) ? 8 : (16 << n)) - 3) @(posedge hclk);
         bus(1'b0, 32'h4, 32'h0);
         check(32'(8'(rd - c0)), 32'h8);
      end
      // Freeze the counter on the idle pin first, so no earlier wrap lies close by.
      bus(1'b1, 32'h0, 32'h28);
      bus(1'b1, 32'h4, 32'hfe);
      bus(1'b1, 32'h0, 32'h8);
      k = 0;
      repeat (10)
      begin
         @(posedge hclk);
         k += int'(timer_irq === 1'b1);
      end
      check(32'(k), 32'h1);
      bus(1'b0, 32'h10, 32'h0);
      check(rd >> 5, 32'h0);
      $display("internal counting done");
      for (int e = 0; e < 2; e++)
      begin
         bus(1'b1, 32'h0, 32'h28 | 32'(e << 4));
         pins.pin_level(1'b0, 3);
         bus(1'b0, 32'h4, 32'h0);
         c0 = rd;
         pins.pin_level(1'b1, 3);
         bus(1'b0, 32'h4, 32'h0);
         check(32'(8'(rd - c0)), 32'(1 - e));
         c0 = rd;
         pins.pin_level(1'b0, 8);
         bus(1'b0, 32'h4, 32'h0);
         check(32'(8'(rd - c0)), 32'(e));
      end
      $display("pin counting done");
      wdt_run(32'h0, 256);
      wdt_run(32'h8, 512);
      ext_reset(1'b1);
      ext_reset(1'b0);
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b1, 32'h8, 32'(c));
         sleep_req <= 1'b1;
         @(posedge hclk);
         sleep_req <= 1'b0;
         wait_sig(1'b1, 1'b1, WAKE[c] - 4, WAKE[c] + 16);
         check(32'(core_reset_n), 32'h1);
      end
      $display("wake delays done");
      give_verdict();
   end
endmodule : tb

`default_nettype wire

// file: dv/twr_monitor.sv
`default_nettype none

module twr_monitor #(
   parameter logic [15:0] P_POR_DIV = 16'h1
) (
   input  wire logic        hclk,             // Clock
   input  wire logic        hresetn,          // Reset, active low
   input  wire logic        hsel,             // Slave select
   input  wire logic [1:0]  htrans,           // Transfer type
   input  wire logic        hwrite,           // Write when high
   input  wire logic [31:0] hrdata,           // Read data
   input  wire logic        master_clear_pin, // External reset pin, active low
   input  wire logic        brownout_det,     // Brown-out indication
   input  wire logic        core_reset_n,     // Internal reset, active low
   input  wire logic [10:0] reset_vector,     // Program counter load value
   input  wire logic        timer_irq,        // Counter wrap pulse
   input  wire logic        wake_pulse        // Wake-up pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] RELEASE_MIN = 32'h400 * 32'(P_POR_DIV);
   logic [31:0] good_cnt_q;
   logic        rd_take;
   assign rd_take = hsel && htrans[1] && !hwrite;

   // ---------------------------------------------------------------------
   // Quiet time of both reset sources
   // ---------------------------------------------------------------------
   // Saturates so that a long run never wraps back below the release limit.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         good_cnt_q <= 32'h0;
      else if (!master_clear_pin || brownout_det)
         good_cnt_q <= 32'h0;
      else if (good_cnt_q != 32'hffffffff)
         good_cnt_q <= good_cnt_q + 32'h1;
   end

   default clocking mcb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence bo_persist;
      brownout_det [*6];
   endsequence
   sequence clear_held;
      !master_clear_pin [*6];
   endsequence
   sequence wake_once;
      wake_pulse && core_reset_n ##1 !wake_pulse;
   endsequence

   vector_fixed_a: assert property (reset_vector == 11'h7ff)
      else $error("reset vector is not the top address");
   release_quiet_a: assert property ($rose(core_reset_n) |-> master_clear_pin && !brownout_det)
      else $error("reset released while a reset source was active");
   rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data changed without a read");
   brownout_hold_a: assert property (bo_persist |-> !core_reset_n)
      else $error("no reset while supply is low");
   clear_hold_a: assert property (clear_held |-> !core_reset_n)
      else $error("no reset while master clear is low");
   release_delay_a: assert property ($rose(core_reset_n) |-> good_cnt_q >= RELEASE_MIN)
      else $error("reset released before the delay ran out");
   irq_pulse_a: assert property (timer_irq |=> !timer_irq [*8])
      else $error("wrap pulse too long or too frequent");
   wake_single_a: assert property (wake_pulse |-> wake_once)
      else $error("wake pulse malformed or during reset");
endmodule : twr_monitor

bind twr_top twr_monitor #(.P_POR_DIV(P_POR_DIV)) u_mon (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hrdata, .master_clear_pin, .brownout_det,
   .core_reset_n, .reset_vector, .timer_irq, .wake_pulse);

`default_nettype wire

// file: dv/twr_pin_model.sv
`default_nettype none

module twr_pin_model (
   input  wire logic hclk,             // Instruction clock
   output logic      timer_pin,        // External timer clock
   output logic      master_clear_pin  // External reset pin, active low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      timer_pin = 1'b0;
      master_clear_pin = 1'b0;
   end

   // Levels are held two cycles at least, or the synchroniser may miss them.
   task automatic pin_level(input logic v, input int hold);
      timer_pin <= v;
      repeat (hold) @(posedge hclk);
   endtask : pin_level

   task automatic clear_level(input logic v);
      master_clear_pin <= v;
      @(posedge hclk);
   endtask : clear_level
endmodule : twr_pin_model

`default_nettype wire

// file: hdl/twr_cfg.svh
`ifndef TWR_CFG_SVH
`define TWR_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (word indices, compared with haddr[4:2])
// ----------------------------------------------------------------------------
`define TWR_ADDR_OPTION  3'h0
`define TWR_ADDR_COUNT   3'h1
`define TWR_ADDR_FUSE    3'h2
`define TWR_ADDR_KICK    3'h3
`define TWR_ADDR_STATUS  3'h4

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TWR_OPT_RESET    8'hff
`define TWR_OPT_SRC_BIT  5
`define TWR_OPT_EDGE_BIT 4
`define TWR_OPT_PSA_BIT  3
`define TWR_FUSE_RESET   3'h3
`define TWR_FUSE_WDT_BIT 2
`define TWR_PC_VECTOR    11'h7ff
`define TWR_DLY_LAST     10'h3ff

// ----------------------------------------------------------------------------
// Timing: the 10-bit delay counter steps once per divider period
// ----------------------------------------------------------------------------
`define TWR_CLK_HZ       64'd40000000
`define TWR_POR_US       64'd72000
`define TWR_WAKE_US_0    64'd60000
`define TWR_WAKE_US_1    64'd1000000
`define TWR_WAKE_US_2    64'd250
`define TWR_WAKE_US_3    64'd18000
`define TWR_US_TO_DIV(t) (((t) * `TWR_CLK_HZ) / 64'd1000000 / 64'd1024)

`endif

// file: hdl/twr_pkg.sv
`default_nettype none

package twr_pkg;

   typedef enum logic [3:0]
   {
      TWR_HOLD  = 4'h1,
      TWR_DELAY = 4'h2,
      TWR_RUN   = 4'h4,
      TWR_SLEEP = 4'h8
   } twr_state_e;

endpackage : twr_pkg

`default_nettype wire

// file: hdl/twr_sync.sv
`default_nettype none

module twr_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,     // Sampling clock
   input  wire logic         rst_n,   // Asynchronous reset, active low
   input  wire logic [W-1:0] async_i, // Asynchronous inputs
   output logic      [W-1:0] sync_o   // Synchronised copies
);

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_q;
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q    <= 1'b0;
               sync_o[i] <= 1'b0;
            end
            else
            begin
               meta_q    <= async_i[i];
               sync_o[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule : twr_sync

`default_nettype wire

// file: hdl/twr_top.sv
// Function
// - 8-bit real-time counter steps per instruction cycle or per chosen pin edge.
// - Prescaler ahead of the counter gives an effective 16-bit count.
// - Option bit 5 clear selects instruction clock, set selects timer pin.
// - Internal mode counts every cycle, or each prescaler output when assigned.
// - Option bit 4 set counts falling pin edges, clear counts rising.
// - Counter wrap from ff to 00 raises an interrupt request.
// - No pending flag records overflow; software samples the counter.
// - Assign bit set places prescaler after watchdog as its postscaler.
// - Assign bit clear places prescaler ahead of the real-time counter.
// - Three rate-select bits choose the prescaler divide ratio.
// - Prescaler count is never readable or writable by software.
// - Prescaler serves exactly one unit at any time.
// - Every reset kind loads the program counter with 7ff.
// - Power-up sets reset latch; delay counter starts after master clear high.
// - Delay counter timeout clears reset latch, typically after 72 ms.
// - Two-bit field sets wake delay: 10 0.25ms, 11 18ms, 00 60ms, 01 1s.
// - Brown-out indication resets the device.
// - Reset stays asserted while brown-out persists, released after it clears.
`include "twr_cfg.svh"
`default_nettype none

module twr_top #(
   parameter logic [15:0] P_POR_DIV   = 16'(`TWR_US_TO_DIV(`TWR_POR_US)),
   parameter logic [15:0] P_WAKE_DIV0 = 16'(`TWR_US_TO_DIV(`TWR_WAKE_US_0)),
   parameter logic [15:0] P_WAKE_DIV1 = 16'(`TWR_US_TO_DIV(`TWR_WAKE_US_1)),
   parameter logic [15:0] P_WAKE_DIV2 = 16'(`TWR_US_TO_DIV(`TWR_WAKE_US_2)),
   parameter logic [15:0] P_WAKE_DIV3 = 16'(`TWR_US_TO_DIV(`TWR_WAKE_US_3))
) (
   input  wire logic        hclk,             // Bus and instruction clock
   input  wire logic        hresetn,          // Power-on reset, active low
   input  wire logic        hsel,             // Slave select
   input  wire logic [31:0] haddr,            // Byte address
   input  wire logic [1:0]  htrans,           // Transfer type
   input  wire logic        hwrite,           // Write when high
   input  wire logic [2:0]  hsize,            // Transfer size
   input  wire logic [31:0] hwdata,           // Write data
   input  wire logic        hready,           // Bus ready
   output logic             hreadyout,        // Slave ready
   output logic             hresp,            // Response, always okay
   output logic      [31:0] hrdata,           // Read data
   input  wire logic        timer_pin,        // External timer clock pin
   input  wire logic        master_clear_pin, // External reset pin, active low
   input  wire logic        brownout_det,     // Supply below minimum when high
   input  wire logic        sleep_req,        // Core asks to power down
   output logic             core_reset_n,     // Internal reset, active low
   output logic      [10:0] reset_vector,     // Program counter load value
   output logic             timer_irq,        // One-cycle pulse on counter wrap
   output logic             wake_pulse        // One-cycle pulse on wake-up
);

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   logic [2:0] pins_s;
   logic       tpin_s;
   logic       master_clear_pin_high_s;
   logic       brown_s;

   twr_sync #(.W(3)) u_sync (
      .clk     (hclk),
      .rst_n   (hresetn),
      .async_i ({brownout_det, master_clear_pin, timer_pin}),
      .sync_o  (pins_s)
   );

   assign tpin_s      = pins_s[0];
   assign master_clear_pin_high_s = pins_s[1];
   assign brown_s     = pins_s[2];

   // -------------------------------------------------------------------------
   // State and registers
   // -------------------------------------------------------------------------
   twr_pkg::twr_state_e state_q;
   twr_pkg::twr_state_e state_d;
   logic [7:0]  option_q;
   logic [2:0]  fuse_q;
   logic [7:0]  realtime_counter_q;
   logic [7:0]  watchdog_counter_q;
   logic [7:0]  prescaler_q;
   logic [9:0]  startup_delay_counter_q;
   logic [15:0] div_q;
   logic [2:0]  cause_q;
   logic        tpin_prev_q;
   logic        a_vld_q;
   logic        a_wr_q;
   logic [2:0]  a_idx_q;
   logic [31:0] hrdata_q;
   logic        irq_q;
   logic        wake_q;
   logic        core_reset_n_q;
   logic [10:0] vector_q;

   // -------------------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------------------
   logic        ap_take;
   logic        dp_write;
   logic        in_hold;

   assign ap_take   = hsel & hready & htrans[1];
   assign dp_write  = a_vld_q & a_wr_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign in_hold   = (state_q == twr_pkg::TWR_HOLD);

   // Offsets above the map alias to nothing; bits 31:5 must be zero to hit.
   logic        addr_hit;
   assign addr_hit = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'b00);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_vld_q <= 1'b0;
         a_wr_q  <= 1'b0;
         a_idx_q <= 3'h0;
      end
      else
      begin
         a_vld_q <= ap_take & addr_hit;
         a_wr_q  <= hwrite;
         a_idx_q <= haddr[4:2];
      end
   end

   // Read data is captured in the address phase, so a read that directly
   // follows a write to the same register returns the value before the write.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_q <= 32'h0;
      end
      else if (ap_take && !hwrite)
      begin
         hrdata_q <= 32'h0;
         if (addr_hit)
         begin
            case (haddr[4:2])
               `TWR_ADDR_OPTION: hrdata_q[7:0] <= option_q;
               `TWR_ADDR_COUNT:  hrdata_q[7:0] <= realtime_counter_q;
               `TWR_ADDR_FUSE:   hrdata_q[2:0] <= fuse_q;
               `TWR_ADDR_KICK:   hrdata_q[7:0] <= watchdog_counter_q;
               `TWR_ADDR_STATUS: hrdata_q[4:0] <= {cause_q, state_q[3], ~core_reset_n_q};
               // The prescaler has no address at all.
               default:          hrdata_q <= 32'h0;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         option_q <= `TWR_OPT_RESET;
      end
      else if (in_hold)
      begin
         option_q <= `TWR_OPT_RESET;
      end
      else if (dp_write && a_idx_q == `TWR_ADDR_OPTION)
      begin
         option_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fuse_q <= `TWR_FUSE_RESET;
      end
      else if (dp_write && a_idx_q == `TWR_ADDR_FUSE)
      begin
         fuse_q <= hwdata[2:0];
      end
   end

   // -------------------------------------------------------------------------
   // Clock source, prescaler and real-time counter
   // -------------------------------------------------------------------------
   logic       prescaler_assign_bit;
   logic       pin_edge;
   logic       src_tick;
   logic       wdt_tick;
   logic       wdt_wrap;
   logic       ps_in;
   logic       ps_out;
   logic       rt_inc;
   logic       wdt_fire;
   logic [7:0] ps_mask;

   assign prescaler_assign_bit      = option_q[`TWR_OPT_PSA_BIT];
   assign pin_edge = option_q[`TWR_OPT_EDGE_BIT] ? (tpin_prev_q & ~tpin_s)
                                                 : (~tpin_prev_q & tpin_s);
   assign src_tick = option_q[`TWR_OPT_SRC_BIT] ? pin_edge : 1'b1;

   // Code n divides by 2 to the power n+1.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_mask
         assign ps_mask[gi] = (3'(gi) <= option_q[2:0]);
      end
   endgenerate

   // One multiplexer feeds the prescaler, so it can never serve both units.
   assign ps_in    = prescaler_assign_bit ? wdt_wrap : src_tick;
   assign ps_out   = ps_in && ((prescaler_q | ~ps_mask) == 8'hff);
   assign rt_inc   = prescaler_assign_bit ? src_tick : ps_out;
   assign wdt_fire = prescaler_assign_bit ? ps_out : wdt_wrap;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tpin_prev_q <= 1'b0;
      end
      else
      begin
         tpin_prev_q <= tpin_s;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prescaler_q <= 8'h0;
      end
      else if (prescaler_assign_bit && dp_write && a_idx_q == `TWR_ADDR_KICK)
      begin
         prescaler_q <= 8'h0;
      end
      else if (ps_in)
      begin
         prescaler_q <= prescaler_q + 8'h1;
      end
   end

   // A software write overrides a count step in the same cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         realtime_counter_q <= 8'h0;
      end
      else if (dp_write && a_idx_q == `TWR_ADDR_COUNT)
      begin
         realtime_counter_q <= hwdata[7:0];
      end
      else if (rt_inc)
      begin
         realtime_counter_q <= realtime_counter_q + 8'h1;
      end
   end

   // The request is a bare pulse; nothing stays pending after it.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= rt_inc && (realtime_counter_q == 8'hff) &&
                  !(dp_write && a_idx_q == `TWR_ADDR_COUNT);
      end
   end

   // -------------------------------------------------------------------------
   // Watchdog
   // -------------------------------------------------------------------------
   assign wdt_tick = fuse_q[`TWR_FUSE_WDT_BIT] & ~in_hold & (state_q != twr_pkg::TWR_DELAY);
   assign wdt_wrap = wdt_tick && (watchdog_counter_q == 8'hff);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         watchdog_counter_q <= 8'h0;
      end
      else if (in_hold || (dp_write && a_idx_q == `TWR_ADDR_KICK))
      begin
         watchdog_counter_q <= 8'h0;
      end
      else if (wdt_tick)
      begin
         watchdog_counter_q <= watchdog_counter_q + 8'h1;
      end
   end

   // -------------------------------------------------------------------------
   // Reset latch, delay counter and power-down
   // -------------------------------------------------------------------------
   logic        rst_req;
   logic [15:0] div_period;
   logic        div_tick;
   logic        dly_done;

   assign rst_req = ~master_clear_pin_high_s | brown_s | wdt_fire;

   always_comb
   begin
      case (fuse_q[1:0])
         2'b00:   div_period = P_WAKE_DIV0;
         2'b01:   div_period = P_WAKE_DIV1;
         2'b10:   div_period = P_WAKE_DIV2;
         default: div_period = P_WAKE_DIV3;
      endcase
      if (state_q == twr_pkg::TWR_DELAY)
      begin
         div_period = P_POR_DIV;
      end
   end

   assign div_tick = (div_q >= div_period - 16'h1);
   assign dly_done = div_tick && (startup_delay_counter_q == `TWR_DLY_LAST);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         twr_pkg::TWR_HOLD:
         begin
            if (master_clear_pin_high_s && !brown_s)
            begin
               state_d = twr_pkg::TWR_DELAY;
            end
         end
         twr_pkg::TWR_DELAY:
         begin
            if (rst_req)
            begin
               state_d = twr_pkg::TWR_HOLD;
            end
            else if (dly_done)
            begin
               state_d = twr_pkg::TWR_RUN;
            end
         end
         twr_pkg::TWR_RUN:
         begin
            if (rst_req)
            begin
               state_d = twr_pkg::TWR_HOLD;
            end
            else if (sleep_req)
            begin
               state_d = twr_pkg::TWR_SLEEP;
            end
         end
         twr_pkg::TWR_SLEEP:
         begin
            if (rst_req)
            begin
               state_d = twr_pkg::TWR_HOLD;
            end
            else if (dly_done)
            begin
               state_d = twr_pkg::TWR_RUN;
            end
         end
         default: state_d = twr_pkg::TWR_HOLD;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= twr_pkg::TWR_HOLD;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // The divider and delay counter restart on every state change.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_q                   <= 16'h0;
         startup_delay_counter_q <= 10'h0;
      end
      else if (state_d != state_q || state_q == twr_pkg::TWR_HOLD ||
               state_q == twr_pkg::TWR_RUN)
      begin
         div_q                   <= 16'h0;
         startup_delay_counter_q <= 10'h0;
      end
      else if (div_tick)
      begin
         div_q                   <= 16'h0;
         startup_delay_counter_q <= startup_delay_counter_q + 10'h1;
      end
      else
      begin
         div_q <= div_q + 16'h1;
      end
   end

   // Cause bits: 2 watchdog, 3 brown-out, 4 master clear. A set beats a
   // write-one clear arriving in the same cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cause_q <= 3'h0;
      end
      else
      begin
         cause_q <= (cause_q & ~((dp_write && a_idx_q == `TWR_ADDR_STATUS) ?
                                 hwdata[4:2] : 3'h0)) |
                    ((state_q != twr_pkg::TWR_HOLD) ?
                     {~master_clear_pin_high_s, brown_s, wdt_fire} : 3'h0);
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         core_reset_n_q <= 1'b0;
         vector_q       <= `TWR_PC_VECTOR;
         wake_q         <= 1'b0;
      end
      else
      begin
         core_reset_n_q <= (state_d == twr_pkg::TWR_RUN) ||
                           (state_d == twr_pkg::TWR_SLEEP);
         vector_q       <= `TWR_PC_VECTOR;
         wake_q         <= (state_q == twr_pkg::TWR_SLEEP) &&
                           (state_d == twr_pkg::TWR_RUN);
      end
   end

   assign core_reset_n = core_reset_n_q;
   assign reset_vector = vector_q;
   assign timer_irq    = irq_q;
   assign wake_pulse   = wake_q;

endmodule : twr_top

`default_nettype wire
